// >>> src/tsl_regs.vh
`ifndef TSL_REGS_VH
`define TSL_REGS_VH

// Register pointer values
`define TSL_PTR_TEMP_HI   8'h00
`define TSL_PTR_TEMP_LO   8'h01
`define TSL_PTR_STATUS    8'h02
`define TSL_PTR_CONFIG    8'h03
`define TSL_PTR_ALERT_HI  8'h04
`define TSL_PTR_ALERT_LO  8'h05
`define TSL_PTR_CRIT_HI   8'h08
`define TSL_PTR_CRIT_LO   8'h09

// Configuration fields
`define TSL_CFG_RES16     7
`define TSL_CFG_MODE_HI   6
`define TSL_CFG_MODE_LO   5
`define TSL_CFG_INTMODE   4
`define TSL_CFG_RESET     8'h00

// Operating modes in the configuration mode field
`define TSL_MODE_CONT     2'b00
`define TSL_MODE_ONESHOT  2'b01
`define TSL_MODE_SPS      2'b10
`define TSL_MODE_SHDN     2'b11

// Status fields
`define TSL_STAT_NRDY     7
`define TSL_STAT_CRIT     6
`define TSL_STAT_ALERT    4

// Limit reset values, 1/128 degree per step (147 C = 0x4980)
`define TSL_CRIT_RESET    16'h4980
`define TSL_ALERT_RESET   16'h2000

// Resolution: low bits cleared in 13-bit results
`define TSL_RES13_MASK    16'hfff8

// Bus address: fixed upper five bits, two pins below
`define TSL_ADDR_BASE     5'h12

// Timing in its own units and clock rate
`define TSL_CLK_KHZ       25000
`define TSL_CONV_MS       240
`define TSL_FAST_MS       6
`define TSL_SPS_CONV_MS   60
`define TSL_SPS_PERIOD_MS 1000

`endif

// >>> src/tsl_limit_out.v
`timescale 1ns/100ps
`default_nettype none
`include "tsl_regs.vh"

module tsl_limit_out (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        rst_i,
    // Result and limit
    input  wire [15:0] temp_i,
    input  wire [15:0] limit_i,
    input  wire        new_result_i,
    // Behaviour control
    input  wire        int_mode_i,
    input  wire        service_i,
    // Output state, high pulls the pin low
    output wire        active_o
);

    reg  active_q;
    wire over;

    // Signed compare of result against limit
    assign over = $signed(temp_i) > $signed(limit_i);

    // Comparator follows each result; interrupt latches until serviced
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            active_q <= 1'b0;
        end else if (!int_mode_i) begin
            if (new_result_i) begin
                active_q <= over;
            end
        end else if (new_result_i && over) begin
            active_q <= 1'b1;
        end else if (service_i) begin
            active_q <= 1'b0;              // Set above wins over service
        end
    end

    assign active_o = active_q;

endmodule
`default_nettype wire

// >>> src/tsl_sensor.v
// How it works
// - Results default to 13 bits, one step is 1/16 degree.
// - Config bit 7 at pointer 0x03 selects 16-bit results.
// - Two address pins pick one of four bus addresses.
// - Critical output activates when temperature exceeds critical limit.
// - Critical limit resets to the code for 147 degrees.
// - Alert output activates when temperature exceeds alert limit.
// - Both outputs selectable between comparator and interrupt behaviour.
// - First conversion after reset finishes in 6 ms.
// - Shutdown mode stops conversions until another mode is chosen.
// - Power-saving mode takes one sample each second.
// - Default result is twos complement, sign plus twelve bits.
// - Normal continuous or one-shot conversion takes 240 ms.
`timescale 1ns/100ps
`default_nettype none
`include "tsl_regs.vh"

module tsl_sensor #(
    parameter CONV_CYC     = `TSL_CONV_MS * `TSL_CLK_KHZ,
    parameter FAST_CYC     = `TSL_FAST_MS * `TSL_CLK_KHZ,
    parameter SPS_CONV_CYC = `TSL_SPS_CONV_MS * `TSL_CLK_KHZ,
    parameter SPS_IDLE_CYC = (`TSL_SPS_PERIOD_MS - `TSL_SPS_CONV_MS) * `TSL_CLK_KHZ
) (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        rst_i,
    // Converter sample, sign plus fifteen bits
    input  wire [15:0] adc_sample_i,
    // Address select pins
    input  wire        addr_select_pin_low_i,
    input  wire        addr_select_pin_high_i,
    // Serial bus
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    // Open-drain limit outputs, enable high pulls low
    output wire        critical_temp_output_o,
    output wire        critical_temp_output_oe_o,
    output wire        alert_output_o,
    output wire        alert_output_oe_o
);

    // Bus states
    localparam [2:0] BS_IDLE = 3'd0, BS_ADDR = 3'd1, BS_ACKA = 3'd2, BS_WR = 3'd3;
    localparam [2:0] BS_ACKW = 3'd4, BS_RD = 3'd5, BS_RACK = 3'd6;
    // Conversion states
    localparam [1:0] CV_IDLE = 2'd0, CV_RUN = 2'd1, CV_WAIT = 2'd2;

    reg  [7:0]  cfg_q;
    reg  [15:0] temp_q;
    reg  [15:0] alert_lim_q;
    reg  [15:0] crit_lim_q;
    reg         nrdy_q;
    reg         store_q;
    reg         svc_q;
    reg         oneshot_go_q;
    reg         fast_q;
    reg  [1:0]  cv_st_q;
    reg  [31:0] cnt_q;
    reg         scl_q;
    reg         sda_q;
    reg  [2:0]  bs_q;
    reg  [3:0]  bit_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  ptr_q;
    reg         rw_q;
    reg         ptr_pend_q;
    reg         nack_q;
    reg         sda_oe_q;
    reg         sda_drv_q;
    reg         rd_temp_lo_q;
    reg  [7:0]  rd_byte;
    reg  [31:0] cv_limit;
    wire [1:0]  mode;
    wire        crit_act;
    wire        alert_act;
    wire [6:0]  my_addr;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_start;
    wire        bus_stop;

    assign mode = cfg_q[`TSL_CFG_MODE_HI:`TSL_CFG_MODE_LO];
    assign my_addr = {`TSL_ADDR_BASE, addr_select_pin_high_i, addr_select_pin_low_i};

    // Bus edge and condition detection on registered pin levels
    assign scl_rise  = scl_i & ~scl_q;
    assign scl_fall  = ~scl_i & scl_q;
    assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
    assign bus_stop  = scl_i & scl_q & ~sda_q & sda_i;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Register read multiplexer
    always @* begin
        case (ptr_q)
            `TSL_PTR_TEMP_HI:  rd_byte = temp_q[15:8];
            `TSL_PTR_TEMP_LO:  rd_byte = temp_q[7:0];
            `TSL_PTR_STATUS:   rd_byte = {nrdy_q, crit_act, 1'b0, alert_act, 4'h0};
            `TSL_PTR_CONFIG:   rd_byte = cfg_q;
            `TSL_PTR_ALERT_HI: rd_byte = alert_lim_q[15:8];
            `TSL_PTR_ALERT_LO: rd_byte = alert_lim_q[7:0];
            `TSL_PTR_CRIT_HI:  rd_byte = crit_lim_q[15:8];
            `TSL_PTR_CRIT_LO:  rd_byte = crit_lim_q[7:0];
            default:           rd_byte = 8'h00;
        endcase
    end

    // Target state machine: address match, pointer, register writes and reads
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            bs_q         <= BS_IDLE;
            bit_q        <= 4'h0;
            sh_q         <= 8'h00;
            ptr_q        <= 8'h00;
            rw_q         <= 1'b0;
            ptr_pend_q   <= 1'b0;
            nack_q       <= 1'b0;
            sda_oe_q     <= 1'b0;
            sda_drv_q    <= 1'b0;
            cfg_q        <= `TSL_CFG_RESET;
            alert_lim_q  <= `TSL_ALERT_RESET;
            crit_lim_q   <= `TSL_CRIT_RESET;
            svc_q        <= 1'b0;
            oneshot_go_q <= 1'b0;
            rd_temp_lo_q <= 1'b0;
        end else begin
            svc_q        <= 1'b0;
            oneshot_go_q <= 1'b0;
            rd_temp_lo_q <= 1'b0;
            if (bus_start) begin
                bs_q       <= BS_ADDR;
                bit_q      <= 4'h0;
                ptr_pend_q <= 1'b1;
                sda_oe_q   <= 1'b0;
            end else if (bus_stop) begin
                bs_q     <= BS_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (bs_q == BS_ADDR || bs_q == BS_WR) begin
                    sh_q  <= {sh_q[6:0], sda_i};
                    bit_q <= bit_q + 4'h1;
                end else if (bs_q == BS_RACK) begin
                    nack_q <= sda_i;
                end
            end else if (scl_fall) begin
                case (bs_q)
                    BS_ADDR: begin
                        if (bit_q == 4'h8) begin
                            if (sh_q[7:1] == my_addr) begin
                                bs_q     <= BS_ACKA;
                                rw_q     <= sh_q[0];
                                sda_oe_q <= 1'b1;
                            end else begin
                                bs_q <= BS_IDLE;
                            end
                        end
                    end
                    BS_ACKA, BS_RACK: begin
                        if (bs_q == BS_RACK && nack_q) begin
                            bs_q     <= BS_IDLE;
                            sda_oe_q <= 1'b0;
                        end else if (bs_q == BS_RACK || rw_q) begin
                            // Load next byte; a status read services latched outputs
                            bs_q         <= BS_RD;
                            sda_oe_q     <= ~rd_byte[7];
                            sh_q         <= {rd_byte[6:0], 1'b0};
                            bit_q        <= 4'h1;
                            ptr_q        <= ptr_q + 8'h01;
                            svc_q        <= (ptr_q == `TSL_PTR_STATUS);
                            rd_temp_lo_q <= (ptr_q == `TSL_PTR_TEMP_LO);
                        end else begin
                            bs_q     <= BS_WR;
                            bit_q    <= 4'h0;
                            sda_oe_q <= 1'b0;
                        end
                    end
                    BS_WR: begin
                        if (bit_q == 4'h8) begin
                            bs_q       <= BS_ACKW;
                            sda_oe_q   <= 1'b1;
                            ptr_pend_q <= 1'b0;
                            if (ptr_pend_q) begin
                                ptr_q <= sh_q;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                                case (ptr_q)
                                    `TSL_PTR_CONFIG: begin
                                        cfg_q        <= sh_q;
                                        oneshot_go_q <= (sh_q[`TSL_CFG_MODE_HI:`TSL_CFG_MODE_LO]
                                                         == `TSL_MODE_ONESHOT);
                                    end
                                    `TSL_PTR_ALERT_HI: alert_lim_q[15:8] <= sh_q;
                                    `TSL_PTR_ALERT_LO: alert_lim_q[7:0]  <= sh_q;
                                    `TSL_PTR_CRIT_HI:  crit_lim_q[15:8]  <= sh_q;
                                    `TSL_PTR_CRIT_LO:  crit_lim_q[7:0]   <= sh_q;
                                    default: ;
                                endcase
                            end
                        end
                    end
                    BS_ACKW: begin
                        bs_q     <= BS_WR;
                        bit_q    <= 4'h0;
                        sda_oe_q <= 1'b0;
                    end
                    BS_RD: begin
                        if (bit_q == 4'h8) begin
                            bs_q     <= BS_RACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            sda_oe_q <= ~sh_q[7];
                            sh_q     <= {sh_q[6:0], 1'b0};
                            bit_q    <= bit_q + 4'h1;
                        end
                    end
                    default: bs_q <= BS_IDLE;
                endcase
            end
        end
    end

    // Conversion length for the current pass
    always @* begin
        if (fast_q) begin
            cv_limit = FAST_CYC;
        end else if (mode == `TSL_MODE_SPS) begin
            cv_limit = SPS_CONV_CYC;
        end else begin
            cv_limit = CONV_CYC;
        end
    end

    // Conversion sequencer: continuous, one-shot, one per second, shutdown
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cv_st_q <= CV_IDLE;
            cnt_q   <= 32'h0;
            fast_q  <= 1'b1;
            store_q <= 1'b0;
            temp_q  <= 16'h0000;
            nrdy_q  <= 1'b1;
        end else begin
            store_q <= 1'b0;
            if (rd_temp_lo_q) begin
                nrdy_q <= 1'b1;
            end
            case (cv_st_q)
                CV_IDLE: begin
                    cnt_q <= 32'h0;
                    if (oneshot_go_q || mode == `TSL_MODE_CONT || mode == `TSL_MODE_SPS) begin
                        cv_st_q <= CV_RUN;
                    end
                end
                CV_RUN: begin
                    if (mode == `TSL_MODE_SHDN) begin
                        cv_st_q <= CV_IDLE;
                    end else if (cnt_q >= cv_limit - 32'h1) begin
                        cnt_q   <= 32'h0;
                        fast_q  <= 1'b0;
                        store_q <= 1'b1;
                        nrdy_q  <= 1'b0;                 // New result wins over read
                        if (cfg_q[`TSL_CFG_RES16]) begin
                            temp_q <= adc_sample_i;
                        end else begin
                            temp_q <= adc_sample_i & `TSL_RES13_MASK;
                        end
                        if (mode == `TSL_MODE_SPS) begin
                            cv_st_q <= CV_WAIT;
                        end else if (mode == `TSL_MODE_ONESHOT) begin
                            cv_st_q <= CV_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                CV_WAIT: begin
                    if (mode != `TSL_MODE_SPS) begin
                        cv_st_q <= CV_IDLE;
                    end else if (cnt_q >= SPS_IDLE_CYC - 1) begin
                        cnt_q   <= 32'h0;
                        cv_st_q <= CV_RUN;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: cv_st_q <= CV_IDLE;
            endcase
        end
    end

    // Critical limit output
    tsl_limit_out u_crit (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .temp_i       (temp_q),
        .limit_i      (crit_lim_q),
        .new_result_i (store_q),
        .int_mode_i   (cfg_q[`TSL_CFG_INTMODE]),
        .service_i    (svc_q),
        .active_o     (crit_act)
    );

    // Alert limit output
    tsl_limit_out u_alert (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .temp_i       (temp_q),
        .limit_i      (alert_lim_q),
        .new_result_i (store_q),
        .int_mode_i   (cfg_q[`TSL_CFG_INTMODE]),
        .service_i    (svc_q),
        .active_o     (alert_act)
    );

    // Open-drain pins only ever pull low
    assign sda_o                     = sda_drv_q;
    assign sda_oe_o                  = sda_oe_q;
    assign critical_temp_output_o    = sda_drv_q;
    assign critical_temp_output_oe_o = crit_act;
    assign alert_output_o            = sda_drv_q;
    assign alert_output_oe_o         = alert_act;

endmodule
`default_nettype wire

// >>> dv/tsl_sensor_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_sensor_monitor #(
    parameter FAST_CYC = 10
) (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // Device pins
    input wire logic [15:0] adc_sample_i,
    input wire logic        addr_select_pin_low_i,
    input wire logic        addr_select_pin_high_i,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic        critical_temp_output_o,
    input wire logic        critical_temp_output_oe_o,
    input wire logic        alert_output_o,
    input wire logic        alert_output_oe_o
);
    logic [31:0] cyc_q;
    // Cycles since reset release, saturating; wide enough to cover the fast first conversion
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cyc_q <= 32'h0;
        end else if (cyc_q != 32'hffffffff) begin
            cyc_q <= cyc_q + 32'h1;
        end
    end
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // Reset and pin levels
    a_rst_quiet_outs: assert property (disable iff (1'b0)
        rst_i |=> !sda_oe_o && !critical_temp_output_oe_o && !alert_output_oe_o)
        else $error("outputs active after reset");
    a_crit_pin_low: assert property (critical_temp_output_o == 1'b0)
        else $error("critical pin driven high");
    a_alert_pin_low: assert property (alert_output_o == 1'b0)
        else $error("alert pin driven high");
    a_sda_pin_low: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    // Data line moves only in the low phase of the bus clock
    a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed with bus clock high");
    a_sda_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data unstable in high phase");
    // First conversion: nothing before it ends, alert due just after
    a_first_alert_wait: assert property (cyc_q < FAST_CYC - 1 |-> !alert_output_oe_o)
        else $error("alert before first result");
    a_first_crit_wait: assert property (
        cyc_q < FAST_CYC - 1 |-> !critical_temp_output_oe_o)
        else $error("critical before first result");
    a_first_alert_due: assert property (
        cyc_q == FAST_CYC && $signed(adc_sample_i) > 16'sh2008 |-> ##[0:4] alert_output_oe_o)
        else $error("alert missing after first result");
    // Main scenarios
    c_ack_seen: cover property ($rose(sda_oe_o));
    c_crit_set: cover property ($rose(critical_temp_output_oe_o));
    c_alert_clr: cover property ($fell(alert_output_oe_o));
endmodule

bind tsl_sensor tsl_sensor_monitor #(.FAST_CYC(FAST_CYC)) u_mon (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .adc_sample_i(adc_sample_i),
    .addr_select_pin_low_i(addr_select_pin_low_i),
    .addr_select_pin_high_i(addr_select_pin_high_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .critical_temp_output_o(critical_temp_output_o),
    .critical_temp_output_oe_o(critical_temp_output_oe_o),
    .alert_output_o(alert_output_o), .alert_output_oe_o(alert_output_oe_o));
`default_nettype wire

// >>> dv/tsl_i2c_host.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_i2c_host (
    // Clock
    input  wire logic core_clk_i,
    // Bus lines
    input  wire logic sda_oe_i,
    output var  logic scl_o,
    output wire logic sda_o
);
    logic drv_q = 1'b1;
    initial scl_o = 1'b1;
    // Pulled-up data line, low while either side pulls
    assign sda_o = drv_q & ~sda_oe_i;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // One bit: set in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        drv_q = b;
        tick(3);
        scl_o = 1'b1;
        tick(2);
        r = sda_o;
        tick(2);
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] r,
                           output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(b9, a);
        ack = ~a;
    endtask
    // Start or repeated start, then stop
    task automatic start_c();
        drv_q = 1'b1;
        tick(1);
        scl_o = 1'b1;
        tick(3);
        drv_q = 1'b0;
        tick(3);
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic stop_c();
        drv_q = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(3);
        drv_q = 1'b1;
        tick(3);
    endtask
    // Register access: pointer, then data bytes or repeated start and read
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input int nb,
                        input logic rd, input logic [15:0] wd,
                        output logic [15:0] rv, output logic ack);
        logic [7:0] r;
        logic       a;
        rv = 16'h0000;
        start_c();
        byte_io({dev, 1'b0}, 1'b1, r, ack);
        if (ack) begin
            byte_io(ptr, 1'b1, r, a);
            for (int k = 0; k < nb && !rd; k++) begin
                byte_io((nb == 2 && k == 0) ? wd[15:8] : wd[7:0], 1'b1, r, a);
            end
            if (rd) begin
                start_c();
                byte_io({dev, 1'b1}, 1'b1, r, a);
                for (int k = 0; k < nb; k++) begin
                    byte_io(8'hff, k == nb - 1, r, a);
                    rv = {rv[7:0], r};
                end
            end
        end
        stop_c();
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tsl_regs.vh"
module tb;
    localparam int CONV = 40;
    localparam int SCONV = 20;
    localparam int SIDLE = 30;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] adc = 16'h2400;
    logic [1:0]  apin = 2'b00;
    wire         scl;
    wire         sda;
    wire         sda_oe;
    wire         crit_oe;
    wire         alert_oe;
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [15:0] rv;
    logic        ack;
    int          n;
    tsl_sensor #(.CONV_CYC(CONV), .FAST_CYC(10), .SPS_CONV_CYC(SCONV),
                 .SPS_IDLE_CYC(SIDLE)) i_dut (
        .core_clk_i(clk), .rst_i(rst), .adc_sample_i(adc),
        .addr_select_pin_low_i(apin[0]), .addr_select_pin_high_i(apin[1]),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .critical_temp_output_o(), .critical_temp_output_oe_o(crit_oe),
        .alert_output_o(), .alert_output_oe_o(alert_oe));
    tsl_i2c_host i_host (.core_clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    // Clock and run limit
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Register access at the strapped address
    task automatic rd(input logic [7:0] ptr, input int nb);
        i_host.xfer({`TSL_ADDR_BASE, apin}, ptr, nb, 1'b1, 16'h0000, rv, ack);
    endtask
    task automatic wr(input logic [7:0] ptr, input int nb, input logic [15:0] wd);
        i_host.xfer({`TSL_ADDR_BASE, apin}, ptr, nb, 1'b0, wd, rv, ack);
    endtask
    // Bounded wait for a limit output level, alert when sel is set
    task automatic wait_pin(input logic want, input logic sel, output int k);
        k = 0;
        while ((sel ? alert_oe : crit_oe) !== want && k < 400) begin
            i_host.tick(1);
            k++;
        end
    endtask
    task automatic t_reset_vals();
        rd(`TSL_PTR_CONFIG, 1);
        chk(rv, 16'h0000);
        rd(`TSL_PTR_CRIT_HI, 2);
        chk(rv, 16'h4980);
        rd(`TSL_PTR_ALERT_HI, 2);
        chk({rv[15:1], alert_oe}, 16'h2001);
        // Unknown pointer reads as zero
        rd(8'h06, 1);
        chk(rv, 16'h0000);
    endtask
    task automatic t_address();
        for (int a = 0; a < 4; a++) begin
            apin = a[1:0];
            rd(`TSL_PTR_CONFIG, 1);
            chk({15'h0, ack}, 16'h0001);
            i_host.xfer({`TSL_ADDR_BASE, ~apin}, `TSL_PTR_CONFIG, 1, 1'b1, 16'h0, rv, ack);
            chk({15'h0, ack}, 16'h0000);
        end
    endtask
    task automatic t_resolution();
        adc = 16'hf3a5;
        i_host.tick(2 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'hf3a0);
        adc = 16'h0c8f;
        i_host.tick(2 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0c88);
        wr(`TSL_PTR_CONFIG, 1, 16'h0080);
        i_host.tick(2 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0c8f);
        wr(`TSL_PTR_CONFIG, 1, 16'h0000);
    endtask
    task automatic t_comparator();
        wr(`TSL_PTR_CRIT_HI, 2, 16'h1000);
        wr(`TSL_PTR_ALERT_HI, 2, 16'h1800);
        rd(`TSL_PTR_ALERT_HI, 2);
        chk(rv, 16'h1800);
        // Below the reset alert limit, so the alert needs the new limit
        adc = 16'h1c00;
        i_host.tick(2 * CONV);
        chk({14'h0, crit_oe, alert_oe}, 16'h0003);
        adc = 16'h1000;
        i_host.tick(2 * CONV);
        chk({14'h0, crit_oe, alert_oe}, 16'h0000);
    endtask
    // Result spacing seen as the distance between two critical edges
    task automatic measure(input logic [15:0] cfg, output int k);
        wr(`TSL_PTR_CONFIG, 1, cfg);
        adc = 16'h1100;
        wait_pin(1'b1, 1'b0, k);
        adc = 16'h0f00;
        wait_pin(1'b0, 1'b0, k);
    endtask
    task automatic t_periods();
        measure(16'h0000, n);
        chk(n[15:0], CONV[15:0]);
        measure(16'h0040, n);
        chk(n[15:0], 16'(SCONV + SIDLE));
    endtask
    task automatic t_interrupt();
        wr(`TSL_PTR_CONFIG, 1, 16'h0010);
        adc = 16'h2100;
        wait_pin(1'b1, 1'b1, n);
        adc = 16'h0c80;
        i_host.tick(3 * CONV);
        chk({14'h0, crit_oe, alert_oe}, 16'h0003);
        rd(`TSL_PTR_STATUS, 1);
        chk(rv, 16'h0050);
        i_host.tick(2);
        chk({14'h0, crit_oe, alert_oe}, 16'h0000);
    endtask
    task automatic t_shutdown();
        wr(`TSL_PTR_CONFIG, 1, 16'h0000);
        adc = 16'h0500;
        i_host.tick(2 * CONV);
        wr(`TSL_PTR_CONFIG, 1, 16'h0060);
        adc = 16'h0600;
        i_host.tick(3 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0500);
        // Temperature read with no new result leaves not-ready set
        rd(`TSL_PTR_STATUS, 1);
        chk(rv, 16'h0080);
        // Writes to the result pointer are dropped
        wr(`TSL_PTR_TEMP_HI, 2, 16'h1234);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0500);
        wr(`TSL_PTR_CONFIG, 1, 16'h0020);
        i_host.tick(2 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0600);
        adc = 16'h0700;
        i_host.tick(3 * CONV);
        rd(`TSL_PTR_TEMP_HI, 2);
        chk(rv, 16'h0600);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        t_reset_vals();
        t_address();
        t_resolution();
        t_comparator();
        t_periods();
        t_interrupt();
        t_shutdown();
        conclude();
    end
endmodule
`default_nettype wire
